// *** src/data_prefetch_unit.v ***
// data prefetch unit: software prefetch, sequential hw prefetch, direct streaming and wc-region store writes
`include "data_prefetch_unit_defs.vh"
module data_prefetch_unit
#(
	parameter ADDR_W = 32,
	parameter SLOTS  = `MAX_OUTSTANDING,
	parameter IDX_W  = 3
)
(
	input  wire                              mclk_i,
	input  wire                              rst_b_i,
	input  wire                              pf_valid_i,
	input  wire [2:0]                        pf_op_i,
	input  wire [ADDR_W-1:0]                 pf_addr_i,
	input  wire                              pf_l1_hit_i,
	input  wire                              emulation_flag_i,
	input  wire                              task_switched_flag_i,
	output reg                               pf_ready_o,
	input  wire                              acc_valid_i,
	input  wire [ADDR_W-1:0]                 acc_addr_i,
	input  wire                              st_valid_i,
	input  wire [ADDR_W-1:0]                 st_addr_i,
	input  wire [63:0]                       st_data_i,
	input  wire                              st_streaming_i,
	input  wire                              st_wc_region_i,
	output reg                               st_ready_o,
	output reg                               mem_rd_valid_o,
	output reg  [ADDR_W-1:0]                 mem_rd_addr_o,
	output reg  [IDX_W-1:0]                  mem_rd_id_o,
	input  wire                              mem_rd_ready_i,
	input  wire                              mem_rd_done_i,
	input  wire [IDX_W-1:0]                  mem_rd_done_id_i,
	output reg                               mem_wr_valid_o,
	output reg  [ADDR_W-1:0]                 mem_wr_addr_o,
	output reg  [63:0]                       mem_wr_data_o,
	input  wire                              mem_wr_ready_i,
	output reg                               l1_fill_o,
	output reg  [ADDR_W-1:0]                 l1_fill_addr_o,
	output reg  [1:0]                        l1_fill_state_o,
	output reg                               l1_fill_way0_o,
	output reg                               l1_fill_no_l2_o,
	output reg                               l2_fill_o,
	output reg  [ADDR_W-1:0]                 l2_fill_addr_o
);
	localparam TAG_W   = ADDR_W - `LINE_OFS_BITS;
	localparam S_IDLE  = 2'h0;
	localparam S_CHECK = 2'h1;
	localparam S_ISSUE = 2'h2;
	localparam HW_AHEAD = `HW_AHEAD_LINES;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// line number of a byte address
	function [TAG_W-1:0] line_of;
		input [ADDR_W-1:0] a;
		begin
			line_of = a[ADDR_W-1:`LINE_OFS_BITS];
		end
	endfunction

	// byte address of a line's first byte
	function [ADDR_W-1:0] base_of;
		input [TAG_W-1:0] l;
		begin
			base_of = {l, {`LINE_OFS_BITS{1'b0}}};
		end
	endfunction

	// ---------------------------------------------------------------
	// request state
	// ---------------------------------------------------------------
	reg [1:0]        st_q;
	reg              req_hw_q;
	reg [2:0]        req_op_q;
	reg [TAG_W-1:0]  req_line_q;
	reg              req_l1hit_q;
	reg [SLOTS-1:0]  busy_q;
	reg [SLOTS-1:0]  slot_hw_q;
	reg [SLOTS-1:0]  slot_nt_q;
	reg [SLOTS-1:0]  slot_st_q;
	reg [TAG_W-1:0]  slot_line_q [0:SLOTS-1];
	reg [TAG_W-1:0]  last_line_q;
	reg              last_vld_q;
	reg              hw_pend_q;
	reg [TAG_W-1:0]  hw_line_q;
	reg [IDX_W-1:0]  free_idx_c;
	reg              free_any_c;
	wire             look_hit;
	wire             tbl_full;
	wire             alloc;
	wire             done;
	wire [TAG_W-1:0] look_line;
	integer          i;

	// flags are deliberately not consulted on the request path
	wire unused_flags = emulation_flag_i | task_switched_flag_i;

	// lowest free slot
	always @*
	begin
		free_idx_c = {IDX_W{1'b0}};
		free_any_c = 1'b0;
		for (i = SLOTS - 1; i >= 0; i = i - 1)
			if (!busy_q[i])
			begin
				free_idx_c = i[IDX_W-1:0];
				free_any_c = 1'b1;
			end
	end

	assign alloc = (st_q == S_ISSUE) && mem_rd_valid_o && mem_rd_ready_i;
	assign done  = mem_rd_done_i && busy_q[mem_rd_done_id_i];

	// line looked up: the one held in check or issue, else the software line being taken, else the queued hardware line
	assign look_line = (st_q != S_IDLE) ? req_line_q :
		(pf_valid_i && !pf_ready_o) ? line_of(pf_addr_i) : hw_line_q;

	// ---------------------------------------------------------------
	// outstanding line table
	// ---------------------------------------------------------------
	line_tag_table
	#(
		.ENTRIES (SLOTS),
		.IDX_W   (IDX_W),
		.TAG_W   (TAG_W)
	)
	u_tags
	(
		.mclk_i     (mclk_i),
		.rst_b_i    (rst_b_i),
		.wr_en_i    (alloc),
		.wr_idx_i   (mem_rd_id_o),
		.wr_tag_i   (req_line_q),
		.clr_en_i   (done),
		.clr_idx_i  (mem_rd_done_id_i),
		.look_tag_i (look_line),
		.look_hit_o (look_hit),
		.full_o     (tbl_full)
	);

	// ---------------------------------------------------------------
	// sequential line detector
	// ---------------------------------------------------------------
	// remembers last line; ascending by one queues line l+3
	always @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			last_vld_q  <= 1'b0;
			last_line_q <= {TAG_W{1'b0}};
			hw_pend_q   <= 1'b0;
			hw_line_q   <= {TAG_W{1'b0}};
		end
		else
		begin
			if (acc_valid_i)
			begin
				last_vld_q  <= 1'b1;
				last_line_q <= line_of(acc_addr_i);
			end
			// only +1 matches, so descending or skipping walks never fire
			if (acc_valid_i && last_vld_q &&
				line_of(acc_addr_i) == last_line_q + 1'b1)
			begin
				hw_pend_q <= 1'b1;
				hw_line_q <= last_line_q + HW_AHEAD[TAG_W-1:0];
			end
			else if (st_q == S_IDLE && !pf_valid_i && hw_pend_q)
				hw_pend_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// request sequencer: one request at a time, software request before queued hardware line
	// ---------------------------------------------------------------
	always @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			st_q           <= S_IDLE;
			req_hw_q       <= 1'b0;
			req_op_q       <= `OP_LOAD;
			req_line_q     <= {TAG_W{1'b0}};
			req_l1hit_q    <= 1'b0;
			pf_ready_o     <= 1'b0;
			mem_rd_valid_o <= 1'b0;
			mem_rd_addr_o  <= {ADDR_W{1'b0}};
			mem_rd_id_o    <= {IDX_W{1'b0}};
		end
		else
		begin
			pf_ready_o <= 1'b0;
			case (st_q)
				S_IDLE:
				begin
					// software request first, then queued hardware line
					if (pf_valid_i && !pf_ready_o)
					begin
						req_hw_q    <= 1'b0;
						req_op_q    <= pf_op_i;
						req_line_q  <= line_of(pf_addr_i);
						req_l1hit_q <= pf_l1_hit_i;
						st_q        <= S_CHECK;
					end
					else if (hw_pend_q && !pf_valid_i)
					begin
						req_hw_q    <= 1'b1;
						req_op_q    <= `OP_LOAD;
						req_line_q  <= hw_line_q;
						req_l1hit_q <= 1'b0;
						st_q        <= S_CHECK;
					end
				end
				S_CHECK:
				begin
					// lookup was launched on the take edge, so it is valid now
					if ((req_l1hit_q && !req_hw_q) || look_hit)
					begin
						pf_ready_o <= !req_hw_q;
						st_q       <= S_IDLE;
					end
					else if (!tbl_full && free_any_c)
					begin
						mem_rd_valid_o <= 1'b1;
						mem_rd_addr_o  <= base_of(req_line_q);
						mem_rd_id_o    <= free_idx_c;
						st_q           <= S_ISSUE;
					end
				end
				S_ISSUE:
				begin
					if (mem_rd_ready_i)
					begin
						mem_rd_valid_o <= 1'b0;
						pf_ready_o     <= !req_hw_q;
						st_q           <= S_IDLE;
					end
				end
				default:
				begin
					st_q           <= S_IDLE;
					mem_rd_valid_o <= 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// slot attributes and fill routing
	// ---------------------------------------------------------------
	always @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			busy_q          <= {SLOTS{1'b0}};
			slot_hw_q       <= {SLOTS{1'b0}};
			slot_nt_q       <= {SLOTS{1'b0}};
			slot_st_q       <= {SLOTS{1'b0}};
			l1_fill_o       <= 1'b0;
			l1_fill_addr_o  <= {ADDR_W{1'b0}};
			l1_fill_state_o <= `FILL_STATE_SHARED;
			l1_fill_way0_o  <= 1'b0;
			l1_fill_no_l2_o <= 1'b0;
			l2_fill_o       <= 1'b0;
			l2_fill_addr_o  <= {ADDR_W{1'b0}};
		end
		else
		begin
			l1_fill_o <= 1'b0;
			l2_fill_o <= 1'b0;
			if (done)
			begin
				busy_q[mem_rd_done_id_i] <= 1'b0;
				if (slot_hw_q[mem_rd_done_id_i])
				begin
					l2_fill_o      <= 1'b1;
					l2_fill_addr_o <= base_of(slot_line_q[mem_rd_done_id_i]);
				end
				else
				begin
					// only the l1 is written; hints fall to load path
					l1_fill_o       <= 1'b1;
					l1_fill_addr_o  <= base_of(slot_line_q[mem_rd_done_id_i]);
					l1_fill_state_o <= slot_st_q[mem_rd_done_id_i] ?
						`FILL_STATE_MOD : `FILL_STATE_SHARED;
					l1_fill_way0_o  <= slot_nt_q[mem_rd_done_id_i];
					l1_fill_no_l2_o <= slot_nt_q[mem_rd_done_id_i];
				end
			end
			// new slot claimed; set wins over a same-slot release
			if (alloc)
			begin
				busy_q[mem_rd_id_o]      <= 1'b1;
				slot_line_q[mem_rd_id_o] <= req_line_q;
				slot_hw_q[mem_rd_id_o]   <= req_hw_q;
				slot_nt_q[mem_rd_id_o]   <= (req_op_q == `OP_NONTEMPORAL);
				slot_st_q[mem_rd_id_o]   <= (req_op_q == `OP_STORE);
			end
		end
	end

	// ---------------------------------------------------------------
	// direct store path for streaming and wc-region stores
	// ---------------------------------------------------------------
	// streaming or wc-region stores go straight to memory writes
	always @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			mem_wr_valid_o <= 1'b0;
			mem_wr_addr_o  <= {ADDR_W{1'b0}};
			mem_wr_data_o  <= 64'h0000_0000_0000_0000;
			st_ready_o     <= 1'b0;
		end
		else
		begin
			st_ready_o <= 1'b0;
			if (mem_wr_valid_o)
			begin
				if (mem_wr_ready_i)
					mem_wr_valid_o <= 1'b0;
			end
			else if (st_valid_i && !st_ready_o &&
				(st_streaming_i || st_wc_region_i))
			begin
				mem_wr_valid_o <= 1'b1;
				mem_wr_addr_o  <= st_addr_i;
				mem_wr_data_o  <= st_data_i;
				st_ready_o     <= 1'b1;
			end
		end
	end
endmodule // data_prefetch_unit

// *** src/data_prefetch_unit_defs.vh ***
// constants for the data prefetch unit
`ifndef DATA_PREFETCH_UNIT_DEFS_VH
`define DATA_PREFETCH_UNIT_DEFS_VH
`define LINE_BYTES        64
`define LINE_OFS_BITS     6
`define MAX_OUTSTANDING   8
`define OP_LOAD           3'h0
`define OP_STORE          3'h1
`define OP_NONTEMPORAL    3'h2
`define OP_HINT_0         3'h3
`define OP_HINT_1         3'h4
`define OP_HINT_2         3'h5
`define FILL_STATE_SHARED 2'h1
`define FILL_STATE_MOD    2'h2
`define HW_AHEAD_LINES    3
`endif

// *** src/line_tag_table.v ***
// table of outstanding line addresses, registered lookup result
module line_tag_table
#(
	parameter ENTRIES = 8,
	parameter IDX_W   = 3,
	parameter TAG_W   = 26
)
(
	input  wire             mclk_i,
	input  wire             rst_b_i,
	input  wire             wr_en_i,
	input  wire [IDX_W-1:0] wr_idx_i,
	input  wire [TAG_W-1:0] wr_tag_i,
	input  wire             clr_en_i,
	input  wire [IDX_W-1:0] clr_idx_i,
	input  wire [TAG_W-1:0] look_tag_i,
	output reg              look_hit_o,
	output reg              full_o
);
	reg [TAG_W-1:0]   tag_q [0:ENTRIES-1];
	reg [ENTRIES-1:0] vld_q;
	reg               hit_c;
	integer           k;

	// compare lookup tag against live slots; a slot freed this edge no longer counts
	always @*
	begin
		hit_c = 1'b0;
		for (k = 0; k < ENTRIES; k = k + 1)
			if (vld_q[k] && tag_q[k] == look_tag_i &&
				!(clr_en_i && clr_idx_i == k[IDX_W-1:0]))
				hit_c = 1'b1;
	end

	// slot storage; a set in the same cycle as a clear wins
	always @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			vld_q      <= {ENTRIES{1'b0}};
			look_hit_o <= 1'b0;
			full_o     <= 1'b0;
		end
		else
		begin
			look_hit_o <= hit_c;
			full_o     <= &vld_q;
			if (clr_en_i)
				vld_q[clr_idx_i] <= 1'b0;
			if (wr_en_i)
			begin
				vld_q[wr_idx_i]  <= 1'b1;
				tag_q[wr_idx_i]  <= wr_tag_i;
			end
		end
	end
endmodule // line_tag_table

// *** tb/data_prefetch_unit_monitor.sv ***
// port checker for the data prefetch unit
`include "data_prefetch_unit_defs.vh"
module data_prefetch_unit_monitor
#(
	parameter ADDR_W = 32
)
(
	input wire logic              mclk_i,
	input wire logic              rst_b_i,
	input wire logic              pf_valid_i,
	input wire logic              pf_l1_hit_i,
	input wire logic              st_valid_i,
	input wire logic [ADDR_W-1:0] st_addr_i,
	input wire logic              st_streaming_i,
	input wire logic              st_wc_region_i,
	input wire logic              st_ready_o,
	input wire logic              mem_rd_valid_o,
	input wire logic [ADDR_W-1:0] mem_rd_addr_o,
	input wire logic              mem_rd_ready_i,
	input wire logic              mem_rd_done_i,
	input wire logic              mem_wr_valid_o,
	input wire logic [ADDR_W-1:0] mem_wr_addr_o,
	input wire logic              mem_wr_ready_i,
	input wire logic              l1_fill_o,
	input wire logic [1:0]        l1_fill_state_o,
	input wire logic              l1_fill_way0_o,
	input wire logic              l1_fill_no_l2_o,
	input wire logic              l2_fill_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// store taken, and read waiting on memory
	sequence st_take;
		st_valid_i && (st_streaming_i || st_wc_region_i) && !mem_wr_valid_o && !st_ready_o;
	endsequence
	sequence rd_stall;
		mem_rd_valid_o && !mem_rd_ready_i;
	endsequence
	a_rd_whole_line: assert property (mem_rd_valid_o |-> mem_rd_addr_o[5:0] == 6'h0)
		else $error("read not line based");
	a_rd_hold_stall: assert property (rd_stall |=> mem_rd_valid_o && $stable(mem_rd_addr_o))
		else $error("read dropped while waiting");
	a_mod_fill_way: assert property (l1_fill_o && l1_fill_state_o == `FILL_STATE_MOD |-> !l1_fill_way0_o)
		else $error("modified fill in way 0");
	a_nt_way_zero: assert property (l1_fill_o |-> l1_fill_way0_o == l1_fill_no_l2_o)
		else $error("way 0 and no-l2 differ");
	a_fill_after_done: assert property (mem_rd_done_i |=> l1_fill_o || l2_fill_o)
		else $error("no fill after read done");
	a_store_direct: assert property (st_take |=> st_ready_o && mem_wr_valid_o
		&& mem_wr_addr_o == $past(st_addr_i))
		else $error("store not written");
	a_plain_store_kept: assert property (st_valid_i && !st_streaming_i && !st_wc_region_i
		|=> !st_ready_o)
		else $error("plain store taken");
	a_hit_no_read: assert property ($rose(pf_valid_i) && pf_l1_hit_i && !mem_rd_valid_o
		|=> !mem_rd_valid_o [*3])
		else $error("read on l1 hit");
	a_wr_hold_stall: assert property (mem_wr_valid_o && !mem_wr_ready_i
		|=> mem_wr_valid_o && $stable(mem_wr_addr_o))
		else $error("write dropped while waiting");
endmodule // data_prefetch_unit_monitor

bind data_prefetch_unit data_prefetch_unit_monitor #(.ADDR_W(ADDR_W)) mon_inst (.*);

// *** tb/mem_model.sv ***
// memory side model: read and write handshakes, read completions
module mem_model
(
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	input  wire logic       slow_i,
	input  wire logic       hold_i,
	input  wire logic       rd_valid_i,
	input  wire logic [2:0] rd_id_i,
	output logic            rd_ready_o,
	output logic            done_o,
	output logic [2:0]      done_id_o,
	input  wire logic       wr_valid_i,
	output logic            wr_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] ids[$];
	int         wait_n;
	logic       tick;
	// accept requests, one completion a cycle unless held
	always @(posedge mclk_i)
	begin
		done_o <= 1'b0;
		done_id_o <= ~done_id_o;
		tick <= ~tick;
		if (!rst_b_i)
		begin
			rd_ready_o <= 1'b0;
			wr_ready_o <= 1'b0;
			done_id_o <= 3'h0;
			tick <= 1'b0;
			wait_n = 0;
			ids.delete();
		end
		else
		begin
			rd_ready_o <= rd_valid_i && !rd_ready_o && wait_n == 0;
			wr_ready_o <= wr_valid_i && !wr_ready_o && (!slow_i || tick);
			if (wait_n > 0)
				wait_n--;
			if (rd_valid_i && rd_ready_o)
			begin
				ids.push_back(rd_id_i);
				wait_n = slow_i ? 3 : 0;
			end
			if (!hold_i && ids.size() != 0)
			begin
				done_o <= 1'b1;
				done_id_o <= ids.pop_front();
			end
		end
	end
endmodule // mem_model

// *** tb/data_prefetch_unit_tb.sv ***
// self-checking bench for the data prefetch unit
`include "data_prefetch_unit_defs.vh"
`define CHK(n, e, g) begin exp_v = e; got_v = g; n_checks++; if (got_v !== exp_v) begin \
	err_count++; $display("CHECK FAILED %s exp %h got %h", n, exp_v, got_v); end end
module data_prefetch_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 0, rst_b_i = 0, pf_valid_i = 0, pf_l1_hit_i = 0, emulation_flag_i = 0;
	logic task_switched_flag_i = 0, acc_valid_i = 0, st_valid_i = 0, st_streaming_i = 0;
	logic st_wc_region_i = 0, slow = 0, hold = 0, stall_done = 0;
	logic [7:0] busy_m = 0;
	logic [2:0] pf_op_i = 0;
	logic [31:0] pf_addr_i = 0, acc_addr_i = 0, st_addr_i = 0, seed = 32'h0000_6239, base;
	logic [63:0] st_data_i = 0;
	logic [95:0] exp_v, got_v, wrq[$];
	logic [31:0] rdq[$], l2q[$];
	logic [35:0] l1q[$];
	int err_count = 0, n_checks = 0;
	wire pf_ready_o, st_ready_o, mem_rd_valid_o, mem_rd_ready_i, mem_rd_done_i, mem_wr_valid_o;
	wire mem_wr_ready_i, l1_fill_o, l1_fill_way0_o, l1_fill_no_l2_o, l2_fill_o;
	wire [2:0] mem_rd_id_o, mem_rd_done_id_i;
	wire [1:0] l1_fill_state_o;
	wire [31:0] mem_rd_addr_o, mem_wr_addr_o, l1_fill_addr_o, l2_fill_addr_o;
	wire [63:0] mem_wr_data_o;

	always #12.5 mclk_i = ~mclk_i;

	data_prefetch_unit data_prefetch_unit_inst (.*);
	mem_model mem_model_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .slow_i(slow), .hold_i(hold),
		.rd_valid_i(mem_rd_valid_o), .rd_id_i(mem_rd_id_o), .rd_ready_o(mem_rd_ready_i),
		.done_o(mem_rd_done_i), .done_id_o(mem_rd_done_id_i), .wr_valid_i(mem_wr_valid_o),
		.wr_ready_o(mem_wr_ready_i));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// note the read and the l1 fill a prefetch of kind k must cause
	task automatic want(input logic [2:0] k, input logic [31:0] a);
		rdq.push_back({a[31:6], 6'h0});
		l1q.push_back({(k == `OP_STORE) ? `FILL_STATE_MOD : `FILL_STATE_SHARED,
			k == `OP_NONTEMPORAL, k == `OP_NONTEMPORAL, a[31:6], 6'h0});
	endtask

	// one software prefetch, held until answered
	task automatic pf(input logic [2:0] k, input logic [31:0] a, input logic h);
		int i = 0;
		@(posedge mclk_i);
		void'(rnd());
		pf_valid_i <= 1;
		pf_op_i <= k;
		pf_addr_i <= a;
		pf_l1_hit_i <= h;
		emulation_flag_i <= seed[3];
		task_switched_flag_i <= seed[9];
		do begin @(posedge mclk_i); i++; end while (pf_ready_o !== 1'b1 && i < 100);
		`CHK("pf done", 1'b1, pf_ready_o)
		pf_valid_i <= 0;
	endtask

	task automatic acc(input logic [31:0] a);
		@(posedge mclk_i);
		acc_valid_i <= 1;
		acc_addr_i <= a;
		@(posedge mclk_i);
		acc_valid_i <= 0;
	endtask

	task automatic st(input logic s, input logic w);
		int i = 0;
		@(posedge mclk_i);
		void'(rnd());
		st_valid_i <= 1;
		st_addr_i <= seed;
		st_data_i <= {seed, ~seed};
		st_streaming_i <= s;
		st_wc_region_i <= w;
		if (s | w)
			wrq.push_back({seed, seed, ~seed});
		do begin @(posedge mclk_i); i++; end while (st_ready_o !== 1'b1 && i < 10);
		`CHK("st taken", s | w, st_ready_o)
		st_valid_i <= 0;
	endtask

	// compare each result with the oldest note of its kind
	always @(posedge mclk_i)
	begin
		if (mem_rd_done_i === 1'b1)
			busy_m[mem_rd_done_id_i] <= 1'b0;
		if (mem_rd_valid_o && mem_rd_ready_i)
		begin
			`CHK("rd", rdq.size() ? rdq.pop_front() : 32'hffff_ffff, mem_rd_addr_o)
			`CHK("rd id free", 1'b0, busy_m[mem_rd_id_o])
			busy_m[mem_rd_id_o] <= 1'b1;
		end
		if (l1_fill_o)
			`CHK("l1", l1q.size() ? l1q.pop_front() : 36'hf_ffff_ffff, {l1_fill_state_o,
				l1_fill_way0_o, l1_fill_no_l2_o, l1_fill_addr_o})
		if (l2_fill_o)
			`CHK("l2", l2q.size() ? l2q.pop_front() : 32'hffff_ffff, l2_fill_addr_o)
		if (mem_wr_valid_o && mem_wr_ready_i)
			`CHK("wr", wrq.size() ? wrq.pop_front() : '1, {mem_wr_addr_o, mem_wr_data_o})
	end

	initial
	begin
		repeat (2) @(posedge mclk_i);
		rst_b_i <= 1;
		for (int k = 0; k < 6; k++)
		begin
			base = rnd();
			slow <= base[4];
			want(k[2:0], base);
			pf(k[2:0], base, 0);
		end
		repeat (20) @(posedge mclk_i);
		$display("test kinds done");
		pf(`OP_LOAD, rnd(), 1);
		repeat (10) @(posedge mclk_i);
		$display("test hit done");
		hold <= 1;
		base = rnd() & 32'hffff_f000;
		for (int k = 0; k < 8; k++)
		begin
			want(`OP_LOAD, base + k * 64);
			pf(`OP_LOAD, base + k * 64 + k, 0);
		end
		pf(`OP_STORE, base + 32'h0000_0005, 0);
		want(`OP_STORE, base + 32'h0000_0400);
		fork
		begin
			pf(`OP_STORE, base + 32'h0000_0400, 0);
			stall_done = 1;
		end
		join_none
		repeat (20) @(posedge mclk_i);
		`CHK("stalled", 1'b0, stall_done)
		hold <= 0;
		repeat (60) @(posedge mclk_i);
		`CHK("served", 1'b1, stall_done)
		$display("test slots done");
		base = rnd() & 32'hfff0_0000;
		rdq.push_back(base + 32'h0000_00c0);
		l2q.push_back(base + 32'h0000_00c0);
		acc(base + 32'h0000_0008);
		acc(base + 32'h0000_0044);
		repeat (20) @(posedge mclk_i);
		acc(base + 32'h0000_1040);
		acc(base + 32'h0000_1000);
		repeat (20) @(posedge mclk_i);
		$display("test hw done");
		slow <= 1;
		st(1, 0);
		st(0, 1);
		st(0, 0);
		st(1, 1);
		repeat (20) @(posedge mclk_i);
		`CHK("left", 0, rdq.size() + l1q.size() + l2q.size() + wrq.size())
		$display("test stores done");
		end_sim;
	end

	// cut a hang short
	initial
	begin
		#(25 * 20000);
		err_count++;
		end_sim;
	end
endmodule // data_prefetch_unit_tb
